// >>> hw/sdrc_core.sv
// Dispatch, branch folding, speculation, completion queue and retirement.
// Assumes fetch, execution units and register files run on the same clock.
`timescale 1ns/1ps
module sdrc_core #(
	parameter int NUM_RENAME = 6,
	parameter int REN_W      = 3
) (
	// Clock and reset
	input  wire logic                                               clk,
	input  wire logic                                               resetn,
	// Fetch side
	input  wire logic                                               fetch_valid,
	input  wire logic [2:0]                                         fetch_class,
	input  wire logic [1:0]                                         fetch_dest_kind,
	input  wire logic                                               fetch_br_known,
	input  wire logic                                               fetch_br_taken,
	input  wire logic                                               fetch_br_lrctr,
	output logic                                                    fetch_ready,
	output logic                                                    redirect_valid,
	output logic                                                    redirect_to_target,
	// Branch resolution
	input  wire logic                                               resolve_valid,
	input  wire logic                                               resolve_taken,
	output logic                                                    spec_active,
	// Execution units
	input  wire logic [sdrc_pkg::NUM_UNITS-1:0]                     unit_busy,
	output logic [sdrc_pkg::NUM_UNITS-1:0]                          issue_valid,
	output logic [sdrc_pkg::NUM_UNITS-1:0][sdrc_pkg::TAG_W-1:0]     issue_tag,
	output logic [sdrc_pkg::NUM_UNITS-1:0][REN_W-1:0]               issue_rename,
	input  wire logic [sdrc_pkg::NUM_UNITS-1:0]                     finish_valid,
	input  wire logic [sdrc_pkg::NUM_UNITS-1:0][sdrc_pkg::TAG_W-1:0] finish_tag,
	output logic                                                    exec_flush,
	output logic                                                    exec_confirm,
	// Rename results and retirement
	output logic [NUM_RENAME-1:0]                                   rename_ready,
	output logic [sdrc_pkg::RETIRE_W-1:0]                           retire_valid,
	output logic [sdrc_pkg::RETIRE_W-1:0][REN_W-1:0]                retire_rename,
	output logic [sdrc_pkg::RETIRE_W-1:0][1:0]                      retire_dest_kind
);
	localparam int IQD = sdrc_pkg::IQ_DEPTH;
	localparam int CQD = sdrc_pkg::CQ_DEPTH;
	localparam int NU  = sdrc_pkg::NUM_UNITS;
	localparam int FS  = sdrc_pkg::FOLD_SPAN;

	// Instruction queue, entry 0 oldest
	logic [sdrc_pkg::CNT_W-1:0] iq_count_reg;
	logic [2:0]                 iq_class_reg [IQD];
	logic [1:0]                 iq_dest_reg  [IQD];
	logic                       iq_known_reg [IQD];
	logic                       iq_taken_reg [IQD];
	logic                       iq_lrctr_reg [IQD];
	// Completion queue, circular
	logic [sdrc_pkg::TAG_W-1:0] cq_head_reg;
	logic [sdrc_pkg::CNT_W-1:0] cq_count_reg;
	logic                       cq_fin_reg   [CQD];
	logic                       cq_spec_reg  [CQD];
	logic                       cq_hasren_reg[CQD];
	logic [REN_W-1:0]           cq_ren_reg   [CQD];
	logic [1:0]                 cq_dest_reg  [CQD];
	// Rename pool
	logic [NUM_RENAME-1:0]      ren_free_reg;
	logic [NUM_RENAME-1:0]      ren_ready_reg;
	// Reservation stations, one entry per unit
	logic [NU-1:0]              rs_valid_reg;
	logic [NU-1:0]              rs_spec_reg;
	logic [sdrc_pkg::TAG_W-1:0] rs_tag_reg [NU];
	logic [REN_W-1:0]           rs_ren_reg [NU];
	// Speculation
	sdrc_pkg::sdrc_spec_e       spec_state_reg;
	logic                       spec_pred_reg;
	logic                       redirect_valid_reg;
	logic                       redirect_to_target_reg;

	// Dispatch decisions
	logic                       slot_ok     [FS];
	logic                       slot_branch [FS];
	logic                       slot_cq     [FS];
	logic                       slot_spec   [FS];
	logic [2:0]                 slot_unit   [FS];
	logic [REN_W-1:0]           slot_ren    [FS];
	logic [sdrc_pkg::TAG_W-1:0] slot_tag    [FS];
	logic                       go;
	logic                       br_used;
	logic                       spec_run;
	logic [NU-1:0]              vac;
	int                         cq_used;
	int                         ren_used;
	int                         n_consume;
	logic                       fold_taken;
	logic                       fold_predict;
	logic                       fold_pred_taken;
	logic [REN_W:0]             ren_a0;
	logic [REN_W:0]             ren_a1;
	logic [NUM_RENAME-1:0]      ren_alloc;
	logic [NUM_RENAME-1:0]      ren_fin;
	logic [NUM_RENAME-1:0]      ren_release;
	logic                       mispredict;
	logic                       confirm;
	logic                       fetch_push;
	logic [sdrc_pkg::CNT_W-1:0] cq_keep;
	logic [sdrc_pkg::TAG_W-1:0] cq_tail;
	logic [sdrc_pkg::TAG_W-1:0] cq_h1;
	int                         cq_room;
	int                         n_retire;

	function automatic logic [REN_W:0] first_set(input logic [NUM_RENAME-1:0] m);
		first_set = '0;
		for (int i = NUM_RENAME - 1; i >= 0; i--)
			if (m[i])
				first_set = {1'b1, REN_W'(i)};
	endfunction

	function automatic logic [sdrc_pkg::TAG_W-1:0] cq_at(input logic [sdrc_pkg::TAG_W-1:0] b,
		input int off);
		int s;
		s = int'(b) + off;
		if (s >= CQD)
			s = s - CQD;
		return sdrc_pkg::TAG_W'(s);
	endfunction

	// Partial decode: class to unit; IU2 preferred for plain integer work
	function automatic logic [2:0] pick_unit(input logic [2:0] cls, input logic [NU-1:0] v);
		pick_unit = sdrc_pkg::NO_UNIT;
		case (cls)
			sdrc_pkg::CLS_INT: begin
				if (v[sdrc_pkg::U_IU2])
					pick_unit = 3'(sdrc_pkg::U_IU2);
				else if (v[sdrc_pkg::U_IU1])
					pick_unit = 3'(sdrc_pkg::U_IU1);
			end
			sdrc_pkg::CLS_INTMUL: if (v[sdrc_pkg::U_IU1]) pick_unit = 3'(sdrc_pkg::U_IU1);
			sdrc_pkg::CLS_FP:     if (v[sdrc_pkg::U_FPU]) pick_unit = 3'(sdrc_pkg::U_FPU);
			sdrc_pkg::CLS_LS:     if (v[sdrc_pkg::U_LSU]) pick_unit = 3'(sdrc_pkg::U_LSU);
			sdrc_pkg::CLS_SYS:    if (v[sdrc_pkg::U_SRU]) pick_unit = 3'(sdrc_pkg::U_SRU);
			default:              pick_unit = sdrc_pkg::NO_UNIT;
		endcase
	endfunction

	assign spec_active = (spec_state_reg == sdrc_pkg::SPEC_PENDING);
	assign mispredict = spec_active && resolve_valid && (resolve_taken != spec_pred_reg);
	assign confirm = spec_active && resolve_valid && (resolve_taken == spec_pred_reg);
	assign fetch_ready = (int'(iq_count_reg) < IQD);
	assign fetch_push = fetch_valid && fetch_ready;
	assign cq_tail = cq_at(cq_head_reg, int'(cq_count_reg));
	assign cq_room = CQD - int'(cq_count_reg);
	assign cq_h1 = cq_at(cq_head_reg, 1);
	assign ren_a0 = first_set(ren_free_reg);
	assign ren_a1 = first_set(ren_free_reg & ~(NUM_RENAME'(1) << ren_a0[REN_W-1:0]));
	assign exec_flush = mispredict;
	assign exec_confirm = confirm;
	assign redirect_valid = redirect_valid_reg;
	assign redirect_to_target = redirect_to_target_reg;
	assign rename_ready = ren_ready_reg;
	// A busy unit holds its station entry, which blocks new work for it
	assign issue_valid = rs_valid_reg & ~unit_busy & ~(mispredict ? rs_spec_reg : '0);

	// Dispatch and fold, strictly in queue order; resolve cycles dispatch nothing
	always_comb begin
		go = !resolve_valid;
		vac = ~rs_valid_reg;
		br_used = 1'b0;
		spec_run = spec_active;
		cq_used = 0;
		ren_used = 0;
		n_consume = 0;
		fold_taken = 1'b0;
		fold_predict = 1'b0;
		fold_pred_taken = 1'b0;
		for (int k = 0; k < FS; k++) begin
			slot_ok[k] = 1'b0;
			slot_branch[k] = 1'b0;
			slot_cq[k] = 1'b0;
			slot_spec[k] = spec_run;
			slot_unit[k] = sdrc_pkg::NO_UNIT;
			slot_ren[k] = (ren_used == 0) ? ren_a0[REN_W-1:0] : ren_a1[REN_W-1:0];
			slot_tag[k] = cq_at(cq_tail, cq_used);
			if (go && k < int'(iq_count_reg)) begin
				if (iq_class_reg[k] == sdrc_pkg::CLS_BRANCH) begin
					slot_branch[k] = 1'b1;
					// One unresolved branch at a time
					if (!br_used && (iq_known_reg[k] || !spec_run)
						&& (!iq_lrctr_reg[k] || cq_room > cq_used)) begin
						slot_ok[k] = 1'b1;
						slot_cq[k] = iq_lrctr_reg[k];
					end
				end else if (k < sdrc_pkg::DISP_SPAN) begin
					slot_unit[k] = pick_unit(iq_class_reg[k], vac);
					if (slot_unit[k] != sdrc_pkg::NO_UNIT && cq_room > cq_used
						&& ((ren_used == 0) ? ren_a0[REN_W] : ren_a1[REN_W])) begin
						slot_ok[k] = 1'b1;
						slot_cq[k] = 1'b1;
					end
				end
			end
			go = go && slot_ok[k];
			if (slot_ok[k]) begin
				n_consume = n_consume + 1;
				if (slot_cq[k])
					cq_used = cq_used + 1;
				if (slot_branch[k]) begin
					br_used = 1'b1;
					if (!iq_known_reg[k]) begin
						fold_predict = 1'b1;
						fold_pred_taken = iq_taken_reg[k];
						spec_run = 1'b1;
					end
					// Anything queued behind a taken branch is wrong-path
					if (iq_taken_reg[k]) begin
						fold_taken = 1'b1;
						go = 1'b0;
					end
				end else begin
					ren_used = ren_used + 1;
					vac[slot_unit[k]] = 1'b0;
				end
			end
		end
	end

	// Retire from the two oldest slots only, never speculative ones
	always_comb begin
		retire_valid = '0;
		retire_valid[0] = cq_count_reg != '0 && cq_fin_reg[cq_head_reg]
			&& !cq_spec_reg[cq_head_reg];
		retire_valid[1] = retire_valid[0] && int'(cq_count_reg) > 1 && cq_fin_reg[cq_h1]
			&& !cq_spec_reg[cq_h1];
		retire_rename[0] = cq_ren_reg[cq_head_reg];
		retire_rename[1] = cq_ren_reg[cq_h1];
		retire_dest_kind[0] = cq_hasren_reg[cq_head_reg] ? cq_dest_reg[cq_head_reg]
			: sdrc_pkg::DEST_NONE;
		retire_dest_kind[1] = cq_hasren_reg[cq_h1] ? cq_dest_reg[cq_h1] : sdrc_pkg::DEST_NONE;
		n_retire = int'(retire_valid[0]) + int'(retire_valid[1]);
	end

	// Rename bookkeeping and flush release; speculative slots sit at the tail
	always_comb begin
		logic [sdrc_pkg::TAG_W-1:0] p;
		logic                       seen;
		p = '0;
		seen = 1'b0;
		ren_alloc = '0;
		ren_fin = '0;
		ren_release = '0;
		cq_keep = cq_count_reg;
		for (int k = 0; k < FS; k++)
			if (slot_ok[k] && !slot_branch[k])
				ren_alloc[slot_ren[k]] = 1'b1;
		for (int u = 0; u < NU; u++)
			if (finish_valid[u] && cq_hasren_reg[finish_tag[u]])
				ren_fin[cq_ren_reg[finish_tag[u]]] = 1'b1;
		for (int r = 0; r < sdrc_pkg::RETIRE_W; r++)
			if (retire_valid[r] && cq_hasren_reg[cq_at(cq_head_reg, r)])
				ren_release[cq_ren_reg[cq_at(cq_head_reg, r)]] = 1'b1;
		for (int i = 0; i < CQD; i++) begin
			p = cq_at(cq_head_reg, i);
			if (i < int'(cq_count_reg) && cq_spec_reg[p]) begin
				if (!seen)
					cq_keep = sdrc_pkg::CNT_W'(i);
				seen = 1'b1;
				if (mispredict && cq_hasren_reg[p])
					ren_release[cq_ren_reg[p]] = 1'b1;
			end
		end
	end

	// Instruction queue: consumed prefix shifts out, fetch appends in order
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			iq_count_reg <= '0;
			for (int i = 0; i < IQD; i++) begin
				iq_class_reg[i] <= '0;
				iq_dest_reg[i] <= '0;
				iq_known_reg[i] <= 1'b0;
				iq_taken_reg[i] <= 1'b0;
				iq_lrctr_reg[i] <= 1'b0;
			end
		end else begin
			for (int i = 0; i < IQD; i++) begin
				if (i + n_consume < IQD) begin
					iq_class_reg[i] <= iq_class_reg[i + n_consume];
					iq_dest_reg[i] <= iq_dest_reg[i + n_consume];
					iq_known_reg[i] <= iq_known_reg[i + n_consume];
					iq_taken_reg[i] <= iq_taken_reg[i + n_consume];
					iq_lrctr_reg[i] <= iq_lrctr_reg[i + n_consume];
				end
			end
			if (mispredict || fold_taken) begin
				iq_count_reg <= '0;
			end else begin
				iq_count_reg <= sdrc_pkg::CNT_W'(int'(iq_count_reg) - n_consume + int'(fetch_push));
				if (fetch_push) begin
					iq_class_reg[int'(iq_count_reg) - n_consume] <= fetch_class;
					iq_dest_reg[int'(iq_count_reg) - n_consume] <= fetch_dest_kind;
					iq_known_reg[int'(iq_count_reg) - n_consume] <= fetch_br_known;
					iq_taken_reg[int'(iq_count_reg) - n_consume] <= fetch_br_taken;
					iq_lrctr_reg[int'(iq_count_reg) - n_consume] <= fetch_br_lrctr;
				end
			end
		end
	end

	// Completion queue
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cq_head_reg <= '0;
			cq_count_reg <= '0;
			for (int i = 0; i < CQD; i++) begin
				cq_fin_reg[i] <= 1'b0;
				cq_spec_reg[i] <= 1'b0;
				cq_hasren_reg[i] <= 1'b0;
				cq_ren_reg[i] <= '0;
				cq_dest_reg[i] <= '0;
			end
		end else begin
			cq_head_reg <= cq_at(cq_head_reg, n_retire);
			cq_count_reg <= sdrc_pkg::CNT_W'(int'(mispredict ? cq_keep : cq_count_reg)
				+ cq_used - n_retire);
			for (int u = 0; u < NU; u++)
				if (finish_valid[u])
					cq_fin_reg[finish_tag[u]] <= 1'b1;
			if (confirm)
				for (int i = 0; i < CQD; i++)
					cq_spec_reg[i] <= 1'b0;
			for (int k = 0; k < FS; k++) begin
				if (slot_ok[k] && slot_cq[k]) begin
					// Folded register-updating branches are done on arrival
					cq_fin_reg[slot_tag[k]] <= slot_branch[k];
					cq_spec_reg[slot_tag[k]] <= slot_spec[k];
					cq_hasren_reg[slot_tag[k]] <= !slot_branch[k];
					cq_ren_reg[slot_tag[k]] <= slot_ren[k];
					cq_dest_reg[slot_tag[k]] <= iq_dest_reg[k];
				end
			end
		end
	end

	// Rename pool
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ren_free_reg <= '1;
			ren_ready_reg <= '0;
		end else begin
			ren_free_reg <= (ren_free_reg & ~ren_alloc) | ren_release;
			ren_ready_reg <= (ren_ready_reg & ~ren_alloc) | ren_fin;
		end
	end

	// Reservation stations
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rs_valid_reg <= '0;
			rs_spec_reg <= '0;
			for (int u = 0; u < NU; u++) begin
				rs_tag_reg[u] <= '0;
				rs_ren_reg[u] <= '0;
			end
		end else begin
			rs_valid_reg <= rs_valid_reg & ~issue_valid & ~(mispredict ? rs_spec_reg : '0);
			if (confirm)
				rs_spec_reg <= '0;
			for (int k = 0; k < FS; k++) begin
				if (slot_ok[k] && !slot_branch[k]) begin
					rs_valid_reg[slot_unit[k]] <= 1'b1;
					rs_spec_reg[slot_unit[k]] <= slot_spec[k];
					rs_tag_reg[slot_unit[k]] <= slot_tag[k];
					rs_ren_reg[slot_unit[k]] <= slot_ren[k];
				end
			end
		end
	end

	always_comb begin
		for (int u = 0; u < NU; u++) begin
			issue_tag[u] = rs_tag_reg[u];
			issue_rename[u] = rs_ren_reg[u];
		end
	end

	// Speculation state and fetch steering
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			spec_state_reg <= sdrc_pkg::SPEC_IDLE;
			spec_pred_reg <= 1'b0;
		end else begin
			case (spec_state_reg)
				sdrc_pkg::SPEC_IDLE: begin
					if (fold_predict) begin
						spec_state_reg <= sdrc_pkg::SPEC_PENDING;
						spec_pred_reg <= fold_pred_taken;
					end
				end
				sdrc_pkg::SPEC_PENDING: if (resolve_valid) spec_state_reg <= sdrc_pkg::SPEC_IDLE;
				default: spec_state_reg <= sdrc_pkg::SPEC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			redirect_valid_reg <= 1'b0;
			redirect_to_target_reg <= 1'b0;
		end else begin
			redirect_valid_reg <= mispredict || fold_taken;
			redirect_to_target_reg <= mispredict ? resolve_taken : 1'b1;
		end
	end
endmodule

// >>> hw/sdrc_pkg.sv
// Shared constants for the dispatch and retire control block.
// Assumes a single core clock; all users reference names as sdrc_pkg::name.
package sdrc_pkg;
	localparam int IQ_DEPTH  = 6;
	localparam int CQ_DEPTH  = 6;
	localparam int CNT_W     = 3;
	localparam int TAG_W     = 3;
	localparam int DISP_SPAN = 2;
	// Branch folder looks one entry deeper than dispatch
	localparam int FOLD_SPAN = 3;
	localparam int RETIRE_W  = 2;
	localparam int NUM_UNITS = 5;
	localparam int U_IU1     = 0;
	localparam int U_IU2     = 1;
	localparam int U_FPU     = 2;
	localparam int U_LSU     = 3;
	localparam int U_SRU     = 4;
	localparam logic [2:0] NO_UNIT = 3'h5;

	typedef enum logic [2:0] {
		CLS_INT    = 3'h0,
		CLS_INTMUL = 3'h1,
		CLS_FP     = 3'h2,
		CLS_LS     = 3'h3,
		CLS_SYS    = 3'h4,
		CLS_BRANCH = 3'h5
	} sdrc_class_e;

	localparam logic [1:0] DEST_NONE      = 2'h0;
	localparam logic [1:0] DEST_GENERAL   = 2'h1;
	localparam logic [1:0] DEST_FLOAT     = 2'h2;
	localparam logic [1:0] DEST_CONDITION = 2'h3;

	typedef enum logic [1:0] {
		SPEC_IDLE    = 2'h1,
		SPEC_PENDING = 2'h2
	} sdrc_spec_e;
endpackage

// >>> verif/sdrc_props.sv
// Concurrent checks on the dispatch and retire control ports.
// Assumes a bind onto sdrc_core; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
module sdrc_props #(
	parameter int NUM_RENAME = 6,
	parameter int REN_W      = 3
) (
	// Clock and reset
	input wire logic                  clk,
	input wire logic                  resetn,
	// Resolution and redirect
	input wire logic                  resolve_valid,
	input wire logic                  resolve_taken,
	input wire logic                  spec_active,
	input wire logic                  redirect_valid,
	input wire logic                  redirect_to_target,
	input wire logic                  exec_flush,
	input wire logic                  exec_confirm,
	// Units and retirement
	input wire logic [4:0]            unit_busy,
	input wire logic [4:0]            issue_valid,
	input wire logic [4:0]            finish_valid,
	input wire logic [NUM_RENAME-1:0] rename_ready,
	input wire logic [1:0]            retire_valid
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sequence s_mispredict;
		resolve_valid && spec_active && exec_flush;
	endsequence
	sequence s_refetch;
		redirect_valid && !spec_active;
	endsequence
	property p_flush_refetch;
		s_mispredict |=> s_refetch;
	endproperty
	a_flush_refetch: assert property (p_flush_refetch)
		else $error("mispredict not followed by a redirect");
	property p_refetch_path;
		exec_flush |=> redirect_to_target == $past(resolve_taken);
	endproperty
	a_refetch_path: assert property (p_refetch_path)
		else $error("redirect after mispredict on the wrong path");
	property p_confirm_clears;
		exec_confirm |-> !exec_flush ##1 !spec_active;
	endproperty
	a_confirm_clears: assert property (p_confirm_clears)
		else $error("confirmed branch left speculation open");
	property p_resolve_answer;
		resolve_valid && spec_active |-> exec_flush ^ exec_confirm;
	endproperty
	a_resolve_answer: assert property (p_resolve_answer)
		else $error("resolution gave neither flush nor confirm");
	property p_idle_resolve;
		!(resolve_valid && spec_active) |-> !exec_flush && !exec_confirm;
	endproperty
	a_idle_resolve: assert property (p_idle_resolve)
		else $error("flush or confirm without a pending branch");
	property p_spec_hold;
		spec_active && !resolve_valid |=> spec_active;
	endproperty
	a_spec_hold: assert property (p_spec_hold)
		else $error("speculation ended without resolution");
	property p_issue_free;
		(issue_valid & unit_busy) == 5'h00;
	endproperty
	a_issue_free: assert property (p_issue_free)
		else $error("issue to a busy unit");
	property p_retire_pair;
		retire_valid[1] |-> retire_valid[0];
	endproperty
	a_retire_pair: assert property (p_retire_pair)
		else $error("second retire slot without the first");
	property p_finish_marks;
		(|(rename_ready & ~$past(rename_ready))) |-> (|$past(finish_valid));
	endproperty
	a_finish_marks: assert property (p_finish_marks)
		else $error("rename marked ready without a finish");
endmodule

bind sdrc_core sdrc_props #(.NUM_RENAME(NUM_RENAME), .REN_W(REN_W)) props_u (
	.clk(clk), .resetn(resetn), .resolve_valid(resolve_valid),
	.resolve_taken(resolve_taken), .spec_active(spec_active),
	.redirect_valid(redirect_valid), .redirect_to_target(redirect_to_target),
	.exec_flush(exec_flush), .exec_confirm(exec_confirm), .unit_busy(unit_busy),
	.issue_valid(issue_valid), .finish_valid(finish_valid),
	.rename_ready(rename_ready), .retire_valid(retire_valid)
);

// >>> verif/sdrc_units.sv
// Behavioural model of the five execution units behind the issue ports.
// Assumes the block's clock and reset; slow mode stretches latency at random.
`timescale 1ns/1ps
module sdrc_units (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               resetn,
	// Issue side
	input  wire logic [4:0]         issue_valid,
	input  wire logic [4:0][2:0]    issue_tag,
	input  wire logic               exec_flush,
	input  wire logic               slow,
	// Finish side
	output logic      [4:0]         unit_busy,
	output logic      [4:0]         finish_valid,
	output logic      [4:0][2:0]    finish_tag
);
	logic [4:0][3:0] cnt_reg;
	logic [4:0][2:0] tag_reg;
	logic [2:0]      noise_reg;

	// Idle tag lines change every cycle so a stale tag never reads as valid
	always_comb begin
		for (int u = 0; u < 5; u++) begin
			unit_busy[u]    = cnt_reg[u] > 4'h1;
			finish_valid[u] = cnt_reg[u] == 4'h1;
			finish_tag[u]   = finish_valid[u] ? tag_reg[u] : noise_reg;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			noise_reg <= 3'h0;
		end else begin
			noise_reg <= noise_reg + 3'h3;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= '0;
			tag_reg <= '0;
		end else begin
			for (int u = 0; u < 5; u++) begin
				// Bench only mispredicts once every unit has gone idle
				if (exec_flush) begin
					cnt_reg[u] <= 4'h0;
				end else if (issue_valid[u] && !unit_busy[u]) begin
					cnt_reg[u] <= ((u == sdrc_pkg::U_IU1) ? 4'h3 : 4'h1)
						+ (slow ? 4'($urandom_range(3)) : 4'h0);
					tag_reg[u] <= issue_tag[u];
				end else if (cnt_reg[u] != 4'h0) begin
					cnt_reg[u] <= cnt_reg[u] - 4'h1;
				end
			end
		end
	end
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the dispatch and retire control block.
// Assumes sdrc_pkg, sdrc_core, sdrc_units and the bound checker are compiled.
`timescale 1ns/1ps
`define CHK(g, e) check_eq(8'(g), 8'(e))
module testbench;
	logic            clk, resetn, fetch_valid, fetch_br_known, fetch_br_taken;
	logic            fetch_br_lrctr, fetch_ready, redirect_valid, redirect_to_target;
	logic            resolve_valid, resolve_taken, spec_active, exec_flush, exec_confirm, slow;
	logic [2:0]      fetch_class;
	logic [1:0]      fetch_dest_kind, retire_valid, exp_d;
	logic [4:0]      unit_busy, issue_valid, finish_valid;
	logic [4:0][2:0] issue_tag, issue_rename, finish_tag;
	logic [5:0]      rename_ready;
	logic [1:0][2:0] retire_rename;
	logic [1:0][1:0] retire_dest_kind;
	logic [1:0]      exp_ret[$];
	logic            exp_rd[$];
	int              failures = 0;
	int              n_checks = 0;

	sdrc_core dut_u (
		.clk(clk), .resetn(resetn), .fetch_valid(fetch_valid), .fetch_class(fetch_class),
		.fetch_dest_kind(fetch_dest_kind), .fetch_br_known(fetch_br_known),
		.fetch_br_taken(fetch_br_taken), .fetch_br_lrctr(fetch_br_lrctr),
		.fetch_ready(fetch_ready), .redirect_valid(redirect_valid),
		.redirect_to_target(redirect_to_target), .resolve_valid(resolve_valid),
		.resolve_taken(resolve_taken), .spec_active(spec_active), .unit_busy(unit_busy),
		.issue_valid(issue_valid), .issue_tag(issue_tag), .issue_rename(issue_rename),
		.finish_valid(finish_valid), .finish_tag(finish_tag), .exec_flush(exec_flush),
		.exec_confirm(exec_confirm), .rename_ready(rename_ready),
		.retire_valid(retire_valid), .retire_rename(retire_rename),
		.retire_dest_kind(retire_dest_kind)
	);
	sdrc_units units_u (
		.clk(clk), .resetn(resetn), .issue_valid(issue_valid), .issue_tag(issue_tag),
		.exec_flush(exec_flush), .slow(slow), .unit_busy(unit_busy),
		.finish_valid(finish_valid), .finish_tag(finish_tag)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check_eq(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic push(input logic [2:0] cls, input logic [1:0] dst,
		input logic kn, tk, lr, ret);
		fetch_valid = 1'b1;
		fetch_class = cls;
		fetch_dest_kind = dst;
		{fetch_br_known, fetch_br_taken, fetch_br_lrctr} = {kn, tk, lr};
		if (ret && (cls != sdrc_pkg::CLS_BRANCH || lr)) exp_ret.push_back(dst);
		for (int i = 0; i < 300 && fetch_ready !== 1'b1; i++) @(posedge clk) #1;
		`CHK(fetch_ready, 1'b1);
		@(posedge clk);
		#1;
	endtask

	task automatic resolve(input logic tk);
		resolve_valid = 1'b1;
		resolve_taken = tk;
		@(posedge clk);
		#1;
		resolve_valid = 1'b0;
	endtask

	task automatic drain();
		for (int i = 0; i < 2000 && exp_ret.size() + exp_rd.size() != 0; i++) @(posedge clk);
		`CHK(exp_ret.size() + exp_rd.size(), 0);
		@(posedge clk);
		#1;
	endtask

	// Results are judged mid-cycle, where combinational outputs have settled
	always @(negedge clk) begin
		if (resetn === 1'b1) begin
			for (int i = 0; i < 2; i++) begin
				if (retire_valid[i] === 1'b1 && exp_ret.size() == 0) begin
					`CHK(retire_valid[i], 1'b0);
				end else if (retire_valid[i] === 1'b1) begin
					exp_d = exp_ret.pop_front();
					`CHK(retire_dest_kind[i], exp_d);
					`CHK(spec_active, 1'b0);
					if (exp_d != 2'h0) `CHK(rename_ready[retire_rename[i]], 1'b1);
				end
			end
			// A freshly issued rename must not yet hold a finished result
			for (int u = 0; u < 5; u++) begin
				if (issue_valid[u] === 1'b1) `CHK(rename_ready[issue_rename[u]], 1'b0);
			end
			if (redirect_valid === 1'b1 && exp_rd.size() == 0) begin
				`CHK(redirect_valid, 1'b0);
			end else if (redirect_valid === 1'b1) begin
				`CHK(redirect_to_target, exp_rd.pop_front());
			end
		end
	end

	initial begin
		#400000;
		failures++;
		stop_test();
	end

	initial begin
		void'($urandom(46463));
		{fetch_valid, fetch_br_known, fetch_br_taken, fetch_br_lrctr} = 4'h0;
		{fetch_class, fetch_dest_kind, resolve_valid, resolve_taken, slow} = 8'h00;
		resetn = 1'b0;
		repeat (16) @(posedge clk);
		#1 resetn = 1'b1;
		// In-order stream of every unit class, then with stretched latency
		for (int i = 0; i < 80; i++) begin
			slow = (i >= 40);
			push(3'($urandom_range(4)), 2'($urandom_range(3)), 1'b0, 1'b0, 1'b0, 1'b1);
		end
		fetch_valid = 1'b0;
		drain();
		for (int k = 0; k < 4; k++) begin
			push(sdrc_pkg::CLS_INT, 2'h1, 1'b0, 1'b0, 1'b0, 1'b1);
			push(sdrc_pkg::CLS_BRANCH, 2'h0, 1'b1, k[0], k[1], 1'b1);
			if (k[0]) exp_rd.push_back(1'b1);
			fetch_valid = 1'b0;
			drain();
			`CHK(spec_active, 1'b0);
		end
		// Predicted not taken, then taken; each confirmed, then refuted
		for (int k = 0; k < 4; k++) begin
			push(sdrc_pkg::CLS_BRANCH, 2'h0, 1'b0, k[1], 1'b0, 1'b0);
			if (k[1]) begin
				// A push in the fold cycle would be dropped as wrong-path
				exp_rd.push_back(1'b1);
				fetch_valid = 1'b0;
				@(posedge clk);
				#1;
			end
			repeat (3) push(3'($urandom_range(4)), 2'h1, 1'b0, 1'b0, 1'b0, !k[0]);
			fetch_valid = 1'b0;
			// Stale ready bits prove nothing; give the slowest unit time to finish
			repeat (30) @(posedge clk);
			#1;
			`CHK(spec_active, 1'b1);
			if (k[0]) exp_rd.push_back(!k[1]);
			resolve(k[0] ^ k[1]);
			drain();
		end
		repeat (8) push(sdrc_pkg::CLS_FP, 2'h2, 1'b0, 1'b0, 1'b0, 1'b1);
		fetch_valid = 1'b0;
		drain();
		resolve(1'b1);
		drain();
		// Reset in mid-run empties both queues
		repeat (3) push(sdrc_pkg::CLS_LS, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0);
		resetn = 1'b0;
		fetch_valid = 1'b0;
		@(posedge clk);
		#1 resetn = 1'b1;
		`CHK(fetch_ready, 1'b1);
		push(sdrc_pkg::CLS_SYS, 2'h3, 1'b0, 1'b0, 1'b0, 1'b1);
		fetch_valid = 1'b0;
		drain();
		stop_test();
	end
endmodule
